// [common/upc_pkg.sv]
// upc_pkg: constants for the usb port fault and attach controller
package upc_pkg;
    // clock
    localparam int CLK_MHZ = 125;
    // intervals in their own units
    localparam int T_DIRECT_MS = 3;
    localparam int T_UV_MS = 2;
    localparam int T_FASTOFF_US = 80;
    localparam int T_DISCH_MS = 100;
    localparam int T_HICCUP_MS = 2000;
    localparam int T_FASTOFF_NS = 700;
    // derived cycle counts
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int CYC_DIRECT = T_DIRECT_MS * CYC_PER_MS;
    localparam int CYC_UV = T_UV_MS * CYC_PER_MS;
    localparam int CYC_FASTOFF = T_FASTOFF_US * CYC_PER_US;
    localparam int CYC_DISCH = T_DISCH_MS * CYC_PER_MS;
    localparam int CYC_HICCUP = T_HICCUP_MS * CYC_PER_MS;
    // fast-off latency budget in cycles, rounded down
    localparam int CYC_FASTOFF_RESP = (T_FASTOFF_NS * CLK_MHZ) / 1000;
    // timer width
    localparam int TMR_W = 28;
    // synchroniser depth
    localparam int SYNC_STAGES = 3;
    // attach state machine
    typedef enum logic [5:0] {
        ST_UNATT  = 6'h01,
        ST_ATT    = 6'h02,
        ST_DISCH  = 6'h04,
        ST_AUDIO  = 6'h08,
        ST_DWAIT  = 6'h10,
        ST_DIRECT = 6'h20
    } upc_att_t;
    // fault state machine
    typedef enum logic [3:0] {
        FS_RUN    = 4'h1,
        FS_UVWAIT = 4'h2,
        FS_HICCUP = 4'h4,
        FS_FOFF   = 4'h8
    } upc_flt_t;
endpackage

// [hw/upc_sync.sv]
// upc_sync: three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module upc_sync
    import upc_pkg::*;
#(
    parameter int W = 1
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pins and filtered levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [W-1:0] lvl_nxt;

    // change counts only once stages two and three agree
    always_comb
    begin
        lvl_nxt = lvl_r;
        for (int k = 0; k < W; k++)
        begin
            if (s2_r[k] == s3_r[k])
            begin
                lvl_nxt[k] = s3_r[k];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end
        else
        begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule // upc_sync

// [hw/upc_ctrl.sv]
// upc_ctrl: fault handling and type-c attach sequencing of a usb charging port switch
`timescale 1ns/1ps
// How it works
// - overcurrent plus low output 2ms: hiccup
// - overcurrent, output high: stay current limiting
// - hiccup: switch off, reset to 5V
// - after 2s retry; repeat or resume
// - short-circuit comparator kills switch fast
// - fast-off holds 80us then restarts
// - persisting short repeats fast-off
// - start disabled, Rp on both pins
// - Rd on either pin means attach
// - VCONN goes to the Ra pin
// - attach enables VBUS and VCONN
// - detach: discharge 100ms, then monitor again
// - Ra on both pins: output off
// - CC1 grounded: direct start after 3ms
// - over-temperature shuts everything down
// - input overvoltage rise resets to 5V
module upc_ctrl
    import upc_pkg::*;
#(
    parameter int HICCUP_CYC = CYC_HICCUP,
    parameter int DISCH_CYC = CYC_DISCH,
    parameter int DIRECT_CYC = CYC_DIRECT,
    parameter int UV_CYC = CYC_UV
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // analog comparators
    input wire logic i_overcurrent_flag,
    input wire logic i_out_uv,
    input wire logic i_short_circuit,
    input wire logic i_over_temp,
    input wire logic i_in_ovp,
    // cc termination detectors
    input wire logic i_cc1_rd,
    input wire logic i_cc2_rd,
    input wire logic i_cc1_ra,
    input wire logic i_cc2_ra,
    input wire logic i_cc1_grounded,
    // power path
    output logic o_switch_on,
    output logic o_discharge_on,
    output logic o_hv_mode_reset,
    output logic o_upstream_feedback_sink_to_5v,
    // cc control and fault status
    output logic o_cc1_rp_on,
    output logic o_cc2_rp_on,
    output logic o_vconn_cc1,
    output logic o_vconn_cc2,
    output logic o_fault_hiccup,
    output logic o_thermal_shutdown
);
    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    logic [9:0] pins;
    logic [9:0] lv;
    logic oc, uv, scp, otp, ovp, rd1, rd2, ra1, ra2, gnd1;

    assign pins = {i_overcurrent_flag, i_out_uv, i_short_circuit, i_over_temp, i_in_ovp,
                   i_cc1_rd, i_cc2_rd, i_cc1_ra, i_cc2_ra, i_cc1_grounded};

    upc_sync #(.W(10)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(pins),
        .o_level(lv)
    );

    assign {oc, uv, scp, otp, ovp, rd1, rd2, ra1, ra2, gnd1} = lv;

    // the sync path costs about 4 cycles, 32ns, well inside the fast-off budget
    // ---------------------------------------------------------------
    // fault sequencer
    // ---------------------------------------------------------------
    upc_flt_t flt_r, flt_nxt;
    logic [TMR_W-1:0] ftmr_r, ftmr_nxt;
    logic hv_rst_r, hv_rst_nxt;
    logic ovp_d_r;

    always_comb
    begin
        flt_nxt = flt_r;
        ftmr_nxt = ftmr_r;
        hv_rst_nxt = 1'b0;
        if (ovp && !ovp_d_r)
        begin
            hv_rst_nxt = 1'b1;
        end
        unique case (flt_r)
            FS_RUN:
            begin
                ftmr_nxt = '0;
                if (scp)
                begin
                    flt_nxt = FS_FOFF;
                end
                else if (oc && uv)
                begin
                    flt_nxt = FS_UVWAIT;
                end
            end
            FS_UVWAIT:
            begin
                ftmr_nxt = ftmr_r + 1'b1;
                if (scp)
                begin
                    flt_nxt = FS_FOFF;
                    ftmr_nxt = '0;
                end
                else if (!(oc && uv))
                begin
                    flt_nxt = FS_RUN;
                end
                else if (ftmr_r >= TMR_W'(UV_CYC - 1))
                begin
                    flt_nxt = FS_HICCUP;
                    ftmr_nxt = '0;
                    hv_rst_nxt = 1'b1;
                end
            end
            FS_HICCUP:
            begin
                ftmr_nxt = ftmr_r + 1'b1;
                if (ftmr_r >= TMR_W'(HICCUP_CYC - 1))
                begin
                    flt_nxt = FS_RUN;
                    ftmr_nxt = '0;
                end
            end
            FS_FOFF:
            begin
                ftmr_nxt = ftmr_r + 1'b1;
                if (ftmr_r >= TMR_W'(CYC_FASTOFF - 1))
                begin
                    // a lingering short re-enters fast-off from run
                    flt_nxt = FS_RUN;
                    ftmr_nxt = '0;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            flt_r <= FS_RUN;
            ftmr_r <= '0;
            hv_rst_r <= 1'b0;
            ovp_d_r <= 1'b0;
        end
        else
        begin
            flt_r <= flt_nxt;
            ftmr_r <= ftmr_nxt;
            hv_rst_r <= hv_rst_nxt;
            ovp_d_r <= ovp;
        end
    end

    // ---------------------------------------------------------------
    // attach sequencer
    // ---------------------------------------------------------------
    upc_att_t att_r, att_nxt;
    logic [TMR_W-1:0] atmr_r, atmr_nxt;
    logic vc1_r, vc1_nxt, vc2_r, vc2_nxt;
    logic sink_seen;

    assign sink_seen = rd1 || rd2;

    always_comb
    begin
        att_nxt = att_r;
        atmr_nxt = '0;
        vc1_nxt = vc1_r;
        vc2_nxt = vc2_r;
        unique case (att_r)
            ST_UNATT:
            begin
                vc1_nxt = 1'b0;
                vc2_nxt = 1'b0;
                if (gnd1)
                begin
                    att_nxt = ST_DWAIT;
                end
                else if (ra1 && ra2)
                begin
                    att_nxt = ST_AUDIO;
                end
                else if (sink_seen)
                begin
                    att_nxt = ST_ATT;
                    vc1_nxt = ra1;
                    vc2_nxt = ra2 && !ra1;
                end
            end
            ST_ATT:
            begin
                if (!sink_seen)
                begin
                    att_nxt = ST_DISCH;
                    vc1_nxt = 1'b0;
                    vc2_nxt = 1'b0;
                end
            end
            ST_DISCH:
            begin
                atmr_nxt = atmr_r + 1'b1;
                if (atmr_r >= TMR_W'(DISCH_CYC - 1))
                begin
                    att_nxt = ST_UNATT;
                    atmr_nxt = '0;
                end
            end
            ST_AUDIO:
            begin
                if (!(ra1 && ra2))
                begin
                    att_nxt = ST_UNATT;
                end
            end
            ST_DWAIT:
            begin
                atmr_nxt = atmr_r + 1'b1;
                if (atmr_r >= TMR_W'(DIRECT_CYC - 1))
                begin
                    att_nxt = ST_DIRECT;
                    atmr_nxt = '0;
                end
            end
            ST_DIRECT:
            begin
                // latched: attach and detach logic stays off
                att_nxt = ST_DIRECT;
            end
            default:
            begin
                att_nxt = ST_UNATT;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            att_r <= ST_UNATT;
            atmr_r <= '0;
            vc1_r <= 1'b0;
            vc2_r <= 1'b0;
        end
        else
        begin
            att_r <= att_nxt;
            atmr_r <= atmr_nxt;
            vc1_r <= vc1_nxt;
            vc2_r <= vc2_nxt;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    logic sw_r, dis_r, rp1_r, rp2_r, ovc1_r, ovc2_r, hic_r, tsd_r;
    logic sw_nxt, fault_off;

    // thermal has no hysteresis pin; comparator itself holds 150/125 window
    assign fault_off = otp || (flt_nxt == FS_HICCUP) || (flt_nxt == FS_FOFF) || scp;

    always_comb
    begin
        sw_nxt = ((att_nxt == ST_ATT) || (att_nxt == ST_DIRECT)) && !fault_off;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sw_r <= 1'b0;
            dis_r <= 1'b0;
            rp1_r <= 1'b0;
            rp2_r <= 1'b0;
            ovc1_r <= 1'b0;
            ovc2_r <= 1'b0;
            hic_r <= 1'b0;
            tsd_r <= 1'b0;
        end
        else
        begin
            sw_r <= sw_nxt;
            dis_r <= (att_nxt == ST_DISCH) && !otp;
            rp1_r <= (att_nxt != ST_DIRECT) && (att_nxt != ST_DWAIT) && !otp;
            rp2_r <= (att_nxt != ST_DIRECT) && (att_nxt != ST_DWAIT) && !otp;
            ovc1_r <= vc1_nxt && (att_nxt == ST_ATT) && !otp;
            ovc2_r <= vc2_nxt && (att_nxt == ST_ATT) && !otp;
            hic_r <= (flt_nxt == FS_HICCUP);
            tsd_r <= otp;
        end
    end

    assign o_switch_on = sw_r;
    assign o_discharge_on = dis_r;
    assign o_hv_mode_reset = hv_rst_r;
    assign o_upstream_feedback_sink_to_5v = hic_r;
    assign o_cc1_rp_on = rp1_r;
    assign o_cc2_rp_on = rp2_r;
    assign o_vconn_cc1 = ovc1_r;
    assign o_vconn_cc2 = ovc2_r;
    assign o_fault_hiccup = hic_r;
    assign o_thermal_shutdown = tsd_r;
endmodule // upc_ctrl

// [tb/upc_ctrl_chk.sv]
// upc_ctrl_chk: port assertions for the usb port controller
`timescale 1ns/1ps
module upc_ctrl_chk
    import upc_pkg::*;
#(
    parameter int HICCUP_CYC = CYC_HICCUP,
    parameter int DISCH_CYC = CYC_DISCH,
    parameter int DIRECT_CYC = CYC_DIRECT,
    parameter int UV_CYC = CYC_UV
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pins
    input wire logic i_short_circuit,
    input wire logic i_in_ovp,
    input wire logic i_overcurrent_flag,
    input wire logic i_cc1_rd,
    input wire logic i_cc1_ra,
    input wire logic i_cc2_ra,
    input wire logic i_cc1_grounded,
    // outputs
    input wire logic o_switch_on,
    input wire logic o_discharge_on,
    input wire logic o_hv_mode_reset,
    input wire logic o_upstream_feedback_sink_to_5v,
    input wire logic o_cc1_rp_on,
    input wire logic o_vconn_cc1,
    input wire logic o_vconn_cc2,
    input wire logic o_fault_hiccup,
    input wire logic o_thermal_shutdown
);
    localparam int FO_RESP = CYC_FASTOFF_RESP;
    logic [27:0] hcnt_r, hcnt_nxt, dcnt_r, dcnt_nxt, wcnt_r, wcnt_nxt;
    logic arm_r, arm_nxt, rp_d_r;
    // -------------------------
    // length counters
    // -------------------------
    always_comb
    begin
        hcnt_nxt = o_fault_hiccup ? hcnt_r + 28'h1 : 28'h0;
        dcnt_nxt = o_discharge_on ? dcnt_r + 28'h1 : 28'h0;
        // armed from the Rp drop until the switch first comes on; the delay is too long for a range
        arm_nxt = !(o_cc1_rp_on || o_switch_on || o_thermal_shutdown) && (arm_r || rp_d_r);
        wcnt_nxt = arm_nxt ? wcnt_r + 28'h1 : 28'h0;
    end
    always_ff @(posedge i_clk)
    begin
        hcnt_r <= i_rst ? 28'h0 : hcnt_nxt;
        dcnt_r <= i_rst ? 28'h0 : dcnt_nxt;
        wcnt_r <= i_rst ? 28'h0 : wcnt_nxt;
        arm_r <= i_rst ? 1'b0 : arm_nxt;
        rp_d_r <= i_rst ? 1'b0 : o_cc1_rp_on;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_gone;
        !o_switch_on && !o_vconn_cc1 && !o_vconn_cc2;
    endsequence
    sequence s_cc_off;
        !o_cc1_rp_on && !o_switch_on;
    endsequence
    AST_HIC_OFF: assert property (o_fault_hiccup |-> !o_switch_on)
        else $error("switch on in hiccup");
    AST_HIC_5V: assert property ($rose(o_fault_hiccup) |-> o_hv_mode_reset && o_upstream_feedback_sink_to_5v)
        else $error("no 5v reset at hiccup");
    AST_HIC_LEN: assert property ($fell(o_fault_hiccup) && !o_thermal_shutdown
        |-> hcnt_r >= HICCUP_CYC - 3 && hcnt_r <= HICCUP_CYC + 3) else $error("hiccup length");
    AST_PULSE: assert property (o_hv_mode_reset |=> !o_hv_mode_reset)
        else $error("mode reset too long");
    AST_OVP: assert property ($rose(i_in_ovp) |-> ##[1:6] o_hv_mode_reset)
        else $error("no mode reset on ovp");
    AST_FASTOFF: assert property ($rose(i_short_circuit) |-> ##[1:FO_RESP] !o_switch_on)
        else $error("fast off late");
    AST_THERM: assert property (o_thermal_shutdown |-> s_gone and !o_cc1_rp_on && !o_discharge_on)
        else $error("output live in shutdown");
    AST_ATTACH: assert property ($rose(i_cc1_rd) && $past(o_cc1_rp_on) && !i_short_circuit
        && !i_overcurrent_flag && !o_discharge_on && !o_thermal_shutdown && !(i_cc1_ra && i_cc2_ra)
        |-> ##[1:6] o_switch_on)
        else $error("attach not powered");
    AST_DISCH_OFF: assert property (o_discharge_on |-> s_gone)
        else $error("power during discharge");
    AST_DISCH_LEN: assert property ($fell(o_discharge_on) && !o_thermal_shutdown
        |-> dcnt_r >= DISCH_CYC - 3 && dcnt_r <= DISCH_CYC + 3) else $error("discharge length");
    AST_AUDIO: assert property ((i_cc1_ra && i_cc2_ra && o_cc1_rp_on)[*7] |-> !o_switch_on)
        else $error("switch on for accessory");
    AST_DIRECT: assert property ($rose(i_cc1_grounded) && o_cc1_rp_on && !o_switch_on
        |-> ##[1:6] s_cc_off ##1 s_cc_off) else $error("direct start");
    AST_DIRECT_DLY: assert property ($rose(o_switch_on) && arm_r
        |-> wcnt_r >= DIRECT_CYC - 4 && wcnt_r <= DIRECT_CYC + 4) else $error("direct start delay");
endmodule // upc_ctrl_chk
bind upc_ctrl upc_ctrl_chk #(.HICCUP_CYC(HICCUP_CYC), .DISCH_CYC(DISCH_CYC), .DIRECT_CYC(DIRECT_CYC),
    .UV_CYC(UV_CYC)) upc_ctrl_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .i_short_circuit(i_short_circuit),
    .i_in_ovp(i_in_ovp), .i_overcurrent_flag(i_overcurrent_flag), .i_cc1_rd(i_cc1_rd), .i_cc1_ra(i_cc1_ra),
    .i_cc2_ra(i_cc2_ra), .i_cc1_grounded(i_cc1_grounded), .o_switch_on(o_switch_on),
    .o_discharge_on(o_discharge_on), .o_hv_mode_reset(o_hv_mode_reset),
    .o_upstream_feedback_sink_to_5v(o_upstream_feedback_sink_to_5v), .o_cc1_rp_on(o_cc1_rp_on),
    .o_vconn_cc1(o_vconn_cc1), .o_vconn_cc2(o_vconn_cc2), .o_fault_hiccup(o_fault_hiccup),
    .o_thermal_shutdown(o_thermal_shutdown));

// [tb/upc_sink_model.sv]
// upc_sink_model: sink, cable and accessory terminations on the cc pins
`timescale 1ns/1ps
module upc_sink_model (
    // pull-ups from the port
    input wire logic i_cc1_rp_on,
    input wire logic i_cc2_rp_on,
    // what is plugged in
    input wire logic i_attach,
    input wire logic i_cable,
    input wire logic i_audio,
    input wire logic i_tie_gnd,
    // plug orientation: high puts the sink on cc2 and the cable Ra on cc1
    input wire logic i_flip,
    // terminations as the port sees them
    output logic o_cc1_rd,
    output logic o_cc2_rd,
    output logic o_cc1_ra,
    output logic o_cc2_ra,
    output logic o_cc1_grounded
);
    // Rd and Ra only read while the pin is pulled up; the ground tie always reads
    assign o_cc1_rd = i_attach & ~i_flip & i_cc1_rp_on;
    assign o_cc2_rd = i_attach & i_flip & i_cc2_rp_on;
    assign o_cc1_ra = (i_audio | (i_cable & i_flip)) & i_cc1_rp_on;
    assign o_cc2_ra = (i_audio | (i_cable & ~i_flip)) & i_cc2_rp_on;
    assign o_cc1_grounded = i_tie_gnd;
endmodule // upc_sink_model

// [tb/upc_ctrl_test.sv]
// upc_ctrl_test: scenario bench for the usb port controller
`timescale 1ns/1ps
module upc_ctrl_test;
    import upc_pkg::*;
    localparam int HIC = 200;
    localparam int DIS = 100;
    localparam int DIR = 50;
    localparam int UV = 30;
    logic i_clk, i_rst, oc, uv, sc, ot, ovp, att, cab, aud, gnd, flp, rd1, rd2, ra1, ra2, g1;
    logic sw, dis, hvr, to5v, rp1, rp2, vc1, vc2, hic, tsd;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    upc_ctrl #(.HICCUP_CYC(HIC), .DISCH_CYC(DIS), .DIRECT_CYC(DIR), .UV_CYC(UV)) upc_ctrl_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_overcurrent_flag(oc), .i_out_uv(uv), .i_short_circuit(sc),
        .i_over_temp(ot), .i_in_ovp(ovp), .i_cc1_rd(rd1), .i_cc2_rd(rd2), .i_cc1_ra(ra1), .i_cc2_ra(ra2),
        .i_cc1_grounded(g1), .o_switch_on(sw), .o_discharge_on(dis), .o_hv_mode_reset(hvr),
        .o_upstream_feedback_sink_to_5v(to5v), .o_cc1_rp_on(rp1), .o_cc2_rp_on(rp2), .o_vconn_cc1(vc1),
        .o_vconn_cc2(vc2), .o_fault_hiccup(hic), .o_thermal_shutdown(tsd));
    upc_sink_model upc_sink_model_inst (.i_cc1_rp_on(rp1), .i_cc2_rp_on(rp2), .i_attach(att), .i_cable(cab),
        .i_audio(aud), .i_tie_gnd(gnd), .i_flip(flp), .o_cc1_rd(rd1), .o_cc2_rd(rd2), .o_cc1_ra(ra1),
        .o_cc2_ra(ra2),
        .o_cc1_grounded(g1));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // whole run is about 12k cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    // -------------------------
    // helpers
    // -------------------------
    task automatic chk(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic wt(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 20000)
        begin
            cyc(1);
            n++;
        end
    endtask
    task automatic rst_dut();
        i_rst = 1'b1;
        {oc, uv, sc, ot, ovp, att, cab, aud, gnd, flp} = '0;
        cyc(16);
        chk(sw | rp1 | dis, 1'b0, "in reset");
        i_rst = 1'b0;
        cyc(4);
        chk(rp1 & rp2 & ~sw, 1'b1, "idle");
    endtask
    task automatic up();
        rst_dut();
        att = 1'b1;
        wt(sw, 1'b1);
    endtask
    // -------------------------
    // scenarios
    // -------------------------
    task automatic t_attach();
        rst_dut();
        cab = 1'b1;
        att = 1'b1;
        wt(sw, 1'b1);
        chk(n <= 7, 1'b1, "attach");
        chk(vc2 & ~vc1, 1'b1, "vconn");
        {att, cab} = 2'b00;
        wt(sw, 1'b0);
        chk(dis & ~vc2 & (n <= 7), 1'b1, "detach");
        wt(dis, 1'b0);
        chk(n >= DIS - 4 && n <= DIS + 2, 1'b1, "discharge");
        att = 1'b1;
        wt(sw, 1'b1);
        chk(~vc1 & ~vc2 & (n <= 7), 1'b1, "reattach");
        att = 1'b0;
        wt(dis, 1'b1);
        wt(dis, 1'b0);
        {flp, cab, att} = 3'b111;
        wt(sw, 1'b1);
        chk(vc1 & ~vc2 & (n <= 7), 1'b1, "flipped");
        $display("end attach");
    endtask
    task automatic t_oc();
        up();
        oc = 1'b1;
        cyc(100);
        chk(sw & ~hic, 1'b1, "limit");
        uv = 1'b1;
        wt(hic, 1'b1);
        chk(n >= UV && n <= UV + 8, 1'b1, "uv time");
        chk(~sw & to5v, 1'b1, "hiccup");
        wt(hic, 1'b0);
        chk(n >= HIC - 4 && n <= HIC + 2, 1'b1, "off time");
        wt(hic, 1'b1);
        chk(n <= UV + 8, 1'b1, "repeat");
        {oc, uv} = 2'b00;
        wt(hic, 1'b0);
        cyc(2);
        chk(sw & ~to5v, 1'b1, "resume");
        $display("end oc");
    endtask
    task automatic t_short();
        up();
        sc = 1'b1;
        wt(sw, 1'b0);
        chk(n <= 87, 1'b1, "fast off");
        cyc(20);
        sc = 1'b0;
        wt(sw, 1'b1);
        chk(n + 20 >= CYC_FASTOFF - 6 && n + 20 <= CYC_FASTOFF + 6, 1'b1, "hold");
        {oc, uv} = 2'b11;
        wt(hic, 1'b1);
        chk(n <= UV + 8, 1'b1, "as oc");
        {oc, uv} = 2'b00;
        wt(sw, 1'b1);
        chk(n <= HIC + 4, 1'b1, "recover");
        $display("end short");
    endtask
    task automatic t_misc();
        rst_dut();
        // an Rd alongside both Ra must still not power the port
        {aud, att} = 2'b11;
        cyc(40);
        chk(sw, 1'b0, "audio");
        {aud, att} = 2'b00;
        ovp = 1'b1;
        wt(hvr, 1'b1);
        chk(n <= 7, 1'b1, "ovp");
        cyc(1);
        chk(hvr | sw, 1'b0, "pulse");
        up();
        ot = 1'b1;
        cyc(8);
        chk(tsd & ~sw & ~rp1 & ~rp2, 1'b1, "hot");
        ot = 1'b0;
        wt(sw, 1'b1);
        chk(n <= DIS + 20, 1'b1, "cool");
        $display("end misc");
    endtask
    task automatic t_direct();
        rst_dut();
        gnd = 1'b1;
        wt(rp1, 1'b0);
        chk(n <= 7, 1'b1, "cc off");
        wt(sw, 1'b1);
        chk(n >= DIR - 4 && n <= DIR + 4, 1'b1, "delay");
        gnd = 1'b0;
        cyc(20);
        chk(sw, 1'b1, "latched");
        $display("end direct");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        t_attach();
        t_oc();
        t_short();
        t_misc();
        t_direct();
        final_report();
    end
endmodule // upc_ctrl_test
